// >>> include/t1_sig_pkg.sv
// constants for the T1 transmit signaling and per-slot control block
package t1_sig_pkg;

	// ----------------------------------------------------------------
	// microport map
	// ----------------------------------------------------------------
	localparam logic [3:0] PAGE_TX_SIG_LO    = 4'h5;   // channels 1 to 16
	localparam logic [3:0] PAGE_TX_SIG_HI    = 4'h6;   // channels 17 to 24
	localparam logic [3:0] PAGE_SLOT_CTRL_LO = 4'h7;   // slots 1 to 16
	localparam logic [3:0] PAGE_SLOT_CTRL_HI = 4'h8;   // slots 17 to 24
	localparam logic [4:0] ADDR_WORD_BASE    = 5'h10;  // first word of a page
	localparam int         WORDS_LO_PAGE     = 16;
	localparam int         NUM_CHANNELS      = 24;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] TX_SIG_RESET      = 4'h0;
	localparam logic [7:0] SLOT_CTRL_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// per-slot control word fields
	// ----------------------------------------------------------------
	localparam int BIT_MESSAGE_INSERT_EN    = 7;
	localparam int BIT_CHANNEL_INVERT       = 6;
	localparam int BIT_REMOTE_SLOT_LOOPBACK = 5;
	localparam int BIT_LOCAL_SLOT_LOOPBACK  = 4;
	localparam int BIT_LINE_TEST_INSERT     = 3;
	localparam int BIT_BACKPLANE_TEST_SEL   = 2;
	localparam int BIT_SIGNALING_SOURCE_SEL = 1;
	localparam int BIT_NO_ROBBED_BIT        = 0;

	// ----------------------------------------------------------------
	// signaling word fields and superframe positions (frame index from 0)
	// ----------------------------------------------------------------
	localparam int         BIT_SIG_A      = 3;
	localparam int         BIT_SIG_B      = 2;
	localparam int         BIT_SIG_C      = 1;
	localparam int         BIT_SIG_D      = 0;
	localparam int         ROBBED_BIT_POS = 0;     // bit position 8 is the lsb
	localparam logic [4:0] FRAME_SIG_A    = 5'h05; // 6th frame
	localparam logic [4:0] FRAME_SIG_B    = 5'h0b; // 12th frame
	localparam logic [4:0] FRAME_SIG_C    = 5'h11; // 18th frame
	localparam logic [4:0] FRAME_SIG_D    = 5'h17; // 24th frame

	// ----------------------------------------------------------------
	// buffering
	// ----------------------------------------------------------------
	localparam int TX_FIFO_DEPTH = 8;
	localparam int BYTE_WIDTH    = 8;

endpackage : t1_sig_pkg

// >>> design/byte_fifo.sv
// small synchronous fifo with registered output stage
`timescale 1ns/100ps
module byte_fifo
	import t1_sig_pkg::*;
#(
	parameter int WIDTH = BYTE_WIDTH,
	parameter int DEPTH = TX_FIFO_DEPTH
) (
	input  wire logic             core_clk_in,   // system clock
	input  wire logic             sys_rst_in,    // synchronous reset, high
	input  wire logic             in_valid_in,   // write request
	input  wire logic [WIDTH-1:0] in_data_in,    // write data
	output logic                  in_ready_out,  // room for a word
	output logic                  out_valid_out, // output word present
	output logic      [WIDTH-1:0] out_data_out,  // output word
	input  wire logic             out_ready_in   // consumer takes word
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	// handshakes on both sides; output stage refills when empty or taken
	assign push       = in_valid_in & in_ready_out;
	assign pop        = (count != '0) & (~out_valid_out | out_ready_in);
	assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);

	// storage write
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// pointers, count and room flag
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_ptr       <= '0;
			rd_ptr       <= '0;
			count        <= '0;
			in_ready_out <= 1'b0;
		end else begin
			wr_ptr       <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr       <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
			count        <= next_count;
			in_ready_out <= (next_count != (PW+1)'(DEPTH));
		end
	end

	// registered output word
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out  <= mem[rd_ptr];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end

endmodule : byte_fifo

// >>> design/t1_tx_signaling_timeslot_ctrl.sv
// T1 transmit robbed-bit signaling and per-time-slot control
`timescale 1ns/100ps
module t1_tx_signaling_timeslot_ctrl
	import t1_sig_pkg::*;
#(
	parameter int CHANNELS = NUM_CHANNELS,
	parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
	input  wire logic       core_clk_in,           // 100 MHz system clock
	input  wire logic       sys_rst_in,            // synchronous reset, high
	// microport
	input  wire logic [3:0] mp_page_in,            // register page
	input  wire logic [4:0] mp_addr_in,            // in-page address
	input  wire logic       mp_wr_in,              // write strobe, one cycle
	input  wire logic       mp_rd_in,              // read strobe, one cycle
	input  wire logic [7:0] mp_wdata_in,           // write data
	output logic      [7:0] mp_rdata_out,          // read data
	output logic            mp_rvalid_out,         // read data valid pulse
	// framer timing and global controls
	input  wire logic       slot_strobe_in,        // one pulse per channel slot
	input  wire logic [4:0] slot_num_in,           // slot 0 to 23
	input  wire logic [4:0] frame_num_in,          // frame in superframe, from 0
	input  wire logic       esf_mode_in,           // 1 ESF, 0 D4
	input  wire logic       nibble_select_in,      // serial signaling nibble
	input  wire logic       test_pattern_sel_in,   // 1 milliwatt, 0 PRBS
	// slot byte streams
	input  wire logic [7:0] serial_data_in,        // backplane transmit byte
	input  wire logic [7:0] serial_control_in,     // backplane control byte
	input  wire logic [7:0] rx_line_in,            // received line byte
	input  wire logic [7:0] tx_message_in,         // transmit message byte
	input  wire logic [7:0] prbs_gen_in,           // PRBS generator byte
	input  wire logic [7:0] milliwatt_in,          // milliwatt generator byte
	// outputs
	output logic            slot_ready_out,        // block can take a slot
	output logic      [7:0] tx_line_out,           // line transmit byte
	output logic            tx_line_valid_out,     // line byte present
	input  wire logic       tx_line_ready_in,      // line side takes byte
	output logic      [7:0] serial_data_out,       // backplane receive byte
	output logic            serial_data_valid_out, // receive byte valid pulse
	output logic      [7:0] rx_loop_out,           // byte looped into receive
	output logic            rx_loop_valid_out,     // loop byte valid pulse
	output logic      [7:0] prbs_det_out,          // byte to PRBS detector
	output logic            prbs_det_valid_out     // detector byte valid
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [3:0] tx_sig_word   [CHANNELS];
	logic [7:0] slot_ctrl_word[CHANNELS];

	// ----------------------------------------------------------------
	// microport decode
	// ----------------------------------------------------------------
	logic       addr_in_page;
	logic [3:0] addr_index;
	logic       page_sig_lo;
	logic       page_sig_hi;
	logic       page_ctl_lo;
	logic       page_ctl_hi;
	logic       hi_index_ok;
	logic       sig_hit;
	logic       ctl_hit;
	logic [4:0] word_channel;
	logic [7:0] read_value;

	// upper page holds only eight words; the rest are unused
	assign addr_in_page = (mp_addr_in[4] == ADDR_WORD_BASE[4]);
	assign addr_index   = mp_addr_in[3:0];
	assign hi_index_ok  = (5'(addr_index) + 5'(WORDS_LO_PAGE)) < 5'(CHANNELS);
	assign page_sig_lo  = (mp_page_in == PAGE_TX_SIG_LO);
	assign page_sig_hi  = (mp_page_in == PAGE_TX_SIG_HI);
	assign page_ctl_lo  = (mp_page_in == PAGE_SLOT_CTRL_LO);
	assign page_ctl_hi  = (mp_page_in == PAGE_SLOT_CTRL_HI);
	assign sig_hit      = addr_in_page & (page_sig_lo | (page_sig_hi & hi_index_ok));
	assign ctl_hit      = addr_in_page & (page_ctl_lo | (page_ctl_hi & hi_index_ok));
	assign word_channel = (page_sig_hi | page_ctl_hi) ?
		5'(5'(addr_index) + 5'(WORDS_LO_PAGE)) : 5'(addr_index);

	// read data selection, unused bits and addresses read zero
	assign read_value = sig_hit ? {4'h0, tx_sig_word[word_channel]} :
		ctl_hit ? slot_ctrl_word[word_channel] : 8'h00;

	// register writes
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < CHANNELS; i++) begin
				tx_sig_word[i]    <= TX_SIG_RESET;
				slot_ctrl_word[i] <= SLOT_CTRL_RESET;
			end
		end else if (mp_wr_in) begin
			if (sig_hit) begin
				tx_sig_word[word_channel] <= mp_wdata_in[3:0];
			end
			if (ctl_hit) begin
				slot_ctrl_word[word_channel] <= mp_wdata_in;
			end
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mp_rdata_out  <= 8'h00;
			mp_rvalid_out <= 1'b0;
		end else begin
			mp_rdata_out  <= mp_rd_in ? read_value : mp_rdata_out;
			mp_rvalid_out <= mp_rd_in;
		end
	end

	// ----------------------------------------------------------------
	// current slot controls
	// ----------------------------------------------------------------
	logic       slot_valid;
	logic [7:0] ctl;
	logic       message_insert_en;
	logic       channel_invert;
	logic       remote_slot_loopback;
	logic       local_slot_loopback;
	logic       line_test_insert;
	logic       backplane_test_sel;
	logic       signaling_source_sel;
	logic       no_robbed_bit;

	assign slot_valid = slot_num_in < 5'(CHANNELS);
	assign ctl        = slot_valid ? slot_ctrl_word[slot_num_in] : SLOT_CTRL_RESET;

	// control fields of the slot now passing
	assign message_insert_en    = ctl[BIT_MESSAGE_INSERT_EN];
	assign channel_invert       = ctl[BIT_CHANNEL_INVERT];
	assign remote_slot_loopback = ctl[BIT_REMOTE_SLOT_LOOPBACK];
	assign local_slot_loopback  = ctl[BIT_LOCAL_SLOT_LOOPBACK];
	assign line_test_insert     = ctl[BIT_LINE_TEST_INSERT];
	assign backplane_test_sel   = ctl[BIT_BACKPLANE_TEST_SEL];
	assign signaling_source_sel = ctl[BIT_SIGNALING_SOURCE_SEL];
	assign no_robbed_bit        = ctl[BIT_NO_ROBBED_BIT];

	// ----------------------------------------------------------------
	// signaling nibble and robbed bit
	// ----------------------------------------------------------------
	logic [3:0] serial_nibble;
	logic [3:0] ram_nibble;
	logic [3:0] sig_nibble;
	logic       frame_a;
	logic       frame_b;
	logic       frame_c;
	logic       frame_d;
	logic       rob_frame;
	logic       rob_value;

	// serial byte of this slot, nibble picked by the global select
	assign serial_nibble = nibble_select_in ? serial_control_in[7:4] :
		serial_control_in[3:0];
	assign ram_nibble    = slot_valid ? tx_sig_word[slot_num_in] : TX_SIG_RESET;
	assign sig_nibble    = signaling_source_sel ? ram_nibble : serial_nibble;

	// frames that carry signaling; D4 has only twelve frames
	assign frame_a   = (frame_num_in == FRAME_SIG_A);
	assign frame_b   = (frame_num_in == FRAME_SIG_B);
	assign frame_c   = esf_mode_in & (frame_num_in == FRAME_SIG_C);
	assign frame_d   = esf_mode_in & (frame_num_in == FRAME_SIG_D);
	assign rob_frame = (frame_a | frame_b | frame_c | frame_d) & ~no_robbed_bit;
	assign rob_value = frame_a ? sig_nibble[BIT_SIG_A] :
		frame_b ? sig_nibble[BIT_SIG_B] :
		frame_c ? sig_nibble[BIT_SIG_C] :
		sig_nibble[BIT_SIG_D];

	// ----------------------------------------------------------------
	// transmit byte
	// ----------------------------------------------------------------
	logic [7:0] backplane_byte;
	logic [7:0] test_byte;
	logic [7:0] tx_source;
	logic [7:0] tx_byte;

	// backplane data inverted per channel before the line
	assign backplane_byte = channel_invert ? ~serial_data_in : serial_data_in;
	assign test_byte      = test_pattern_sel_in ? milliwatt_in : prbs_gen_in;

	// source priority: test, remote loop, message, backplane
	assign tx_source = line_test_insert ? test_byte :
		remote_slot_loopback ? rx_line_in :
		message_insert_en ? tx_message_in :
		backplane_byte;

	// robbed bit replaces bit position 8 in signaling frames
	always_comb begin
		tx_byte = tx_source;
		if (rob_frame) begin
			tx_byte[ROBBED_BIT_POS] = rob_value;
		end
	end

	// ----------------------------------------------------------------
	// receive side byte
	// ----------------------------------------------------------------
	logic [7:0] rx_source;
	logic [7:0] rx_byte;
	logic       rx_milliwatt;
	logic       rx_to_detector;
	logic       slot_take;

	// local loop replaces the received slot with the transmit slot
	assign rx_source      = local_slot_loopback ? tx_byte : rx_line_in;
	assign rx_milliwatt   = backplane_test_sel & test_pattern_sel_in;
	assign rx_to_detector = backplane_test_sel & ~test_pattern_sel_in;
	assign rx_byte        = rx_milliwatt ? milliwatt_in :
		channel_invert ? ~rx_source : rx_source;

	// a slot is taken only while the line fifo has room
	assign slot_take = slot_strobe_in & slot_valid & slot_ready_out;

	// backplane, loop and detector outputs
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			serial_data_out       <= 8'h00;
			serial_data_valid_out <= 1'b0;
			rx_loop_out           <= 8'h00;
			rx_loop_valid_out     <= 1'b0;
			prbs_det_out          <= 8'h00;
			prbs_det_valid_out    <= 1'b0;
		end else begin
			serial_data_out       <= slot_take ? rx_byte : serial_data_out;
			serial_data_valid_out <= slot_take;
			rx_loop_out           <= slot_take ? rx_source : rx_loop_out;
			rx_loop_valid_out     <= slot_take & local_slot_loopback;
			prbs_det_out          <= slot_take ? rx_line_in : prbs_det_out;
			prbs_det_valid_out    <= slot_take & rx_to_detector;
		end
	end

	// ----------------------------------------------------------------
	// line fifo
	// ----------------------------------------------------------------
	logic fifo_in_ready;

	// ready mirrors the fifo's registered room flag
	assign slot_ready_out = fifo_in_ready;

	byte_fifo #(
		.WIDTH (BYTE_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk_in   (core_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (slot_take),
		.in_data_in    (tx_byte),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (tx_line_valid_out),
		.out_data_out  (tx_line_out),
		.out_ready_in  (tx_line_ready_in)
	);

endmodule : t1_tx_signaling_timeslot_ctrl

// >>> tb/t1_backplane_model.sv
// backplane model: signaling nibble source and line byte sink
`timescale 1ns/100ps
module t1_backplane_model (
	input  wire logic       core_clk_in,        // system clock
	input  wire logic       sys_rst_in,         // sync reset, high
	input  wire logic       nibble_select_in,   // nibble carrying signaling
	input  wire logic [3:0] abcd_in,            // signaling bits to send
	output logic      [7:0] serial_control_out, // control stream byte
	input  wire logic       stall_in,           // hold off the line side
	input  wire logic       line_valid_in,      // line byte offered
	input  wire logic [7:0] line_data_in,       // line byte
	output logic            line_ready_out,     // line byte taken
	output logic      [7:0] got_out,            // last byte taken
	output logic      [7:0] got_cnt_out         // bytes taken
);
	// signaling sits in the chosen nibble, the other carries its inverse as junk
	assign serial_control_out = nibble_select_in ? {abcd_in, ~abcd_in}
		: {~abcd_in, abcd_in};
	assign line_ready_out = !stall_in;
	// capture each byte at its handshake edge
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			got_out     <= 8'h00;
			got_cnt_out <= 8'h00;
		end else if (line_valid_in && line_ready_out) begin
			got_out     <= line_data_in;
			got_cnt_out <= got_cnt_out + 8'h01;
		end
	end
endmodule : t1_backplane_model

// >>> tb/t1_tx_sig_checker.sv
// port assertions for the transmit signaling block
`timescale 1ns/100ps
module t1_tx_sig_checker
	import t1_sig_pkg::*;
(
	input wire logic       core_clk_in,           // clock
	input wire logic       sys_rst_in,            // reset
	input wire logic [3:0] mp_page_in,            // page
	input wire logic [4:0] mp_addr_in,            // address
	input wire logic       mp_rd_in,              // read strobe
	input wire logic [7:0] mp_rdata_out,          // read data
	input wire logic       mp_rvalid_out,         // read valid
	input wire logic       slot_strobe_in,        // slot pulse
	input wire logic [4:0] slot_num_in,           // slot number
	input wire logic       test_pattern_sel_in,   // test select
	input wire logic [7:0] rx_line_in,            // line byte
	input wire logic       slot_ready_out,        // slot room
	input wire logic       serial_data_valid_out, // rx valid
	input wire logic       rx_loop_valid_out,     // loop valid
	input wire logic [7:0] prbs_det_out,          // detector byte
	input wire logic       prbs_det_valid_out     // detector valid
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// decodes of the register map and of a taken slot
	wire hi_page  = (mp_page_in == PAGE_TX_SIG_HI) || (mp_page_in == PAGE_SLOT_CTRL_HI);
	wire sig_page = (mp_page_in == PAGE_TX_SIG_LO) || (mp_page_in == PAGE_TX_SIG_HI);
	wire in_map   = (mp_page_in >= PAGE_TX_SIG_LO) && (mp_page_in <= PAGE_SLOT_CTRL_HI);
	wire hole     = in_map && ((mp_addr_in < ADDR_WORD_BASE) || (hi_page && mp_addr_in > 5'h17));
	wire take     = slot_strobe_in && (slot_num_in < 5'd24) && slot_ready_out;
	a_read_answers: assert property (mp_rd_in |=> mp_rvalid_out)
		else $error("read not answered next cycle");
	a_answer_has_read: assert property (mp_rvalid_out |-> $past(mp_rd_in))
		else $error("read valid without read");
	a_sig_upper_zero: assert property (mp_rd_in && sig_page |=> mp_rdata_out[7:4] == 4'h0)
		else $error("signaling upper bits not zero");
	a_unmapped_zero: assert property (mp_rd_in && hole |=> mp_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_slot_answered: assert property (take |=> serial_data_valid_out)
		else $error("taken slot gave no receive byte");
	a_answer_has_slot: assert property (serial_data_valid_out |-> $past(take))
		else $error("receive byte without a slot");
	a_loop_with_rx: assert property (rx_loop_valid_out |-> serial_data_valid_out)
		else $error("loop byte without receive byte");
	a_det_raw_prbs: assert property (prbs_det_valid_out |->
		!$past(test_pattern_sel_in) && prbs_det_out == $past(rx_line_in))
		else $error("detector byte wrong");
endmodule : t1_tx_sig_checker
bind t1_tx_signaling_timeslot_ctrl t1_tx_sig_checker u_chk (
	.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .mp_page_in(mp_page_in),
	.mp_addr_in(mp_addr_in), .mp_rd_in(mp_rd_in), .mp_rdata_out(mp_rdata_out),
	.mp_rvalid_out(mp_rvalid_out), .slot_strobe_in(slot_strobe_in),
	.slot_num_in(slot_num_in), .test_pattern_sel_in(test_pattern_sel_in),
	.rx_line_in(rx_line_in), .slot_ready_out(slot_ready_out),
	.serial_data_valid_out(serial_data_valid_out), .rx_loop_valid_out(rx_loop_valid_out),
	.prbs_det_out(prbs_det_out), .prbs_det_valid_out(prbs_det_valid_out));

// >>> tb/tb_t1_tx_signaling_timeslot_ctrl.sv
// self-checking bench for the transmit signaling and slot control block
`timescale 1ns/100ps
module tb_t1_tx_signaling_timeslot_ctrl
	import t1_sig_pkg::*;
;
	localparam logic [7:0] MSG = 8'h3c, PRBS = 8'h96, MW = 8'h1e;
	logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stb = 1'b0, esf = 1'b0;
	logic       nsel = 1'b0, tsel = 1'b0, stall = 1'b0;
	logic [3:0] page = 4'h0, abcd = 4'h0;
	logic [4:0] addr = 5'h00, slot = 5'h00, frame = 5'h00;
	logic [7:0] wdata = 8'h00, sdata = 8'h00, rxb = 8'h00;
	logic [7:0] ctl, got, rdata, txd, sdo, lpo, deto, cnt;
	logic       rvalid, rdy, txv, txr, sdv, lpv, detv;
	int         miscompares = 0, n_compared = 0;
	// clock
	initial begin
		forever #5 clk = ~clk;
	end
	t1_tx_signaling_timeslot_ctrl uut (
		.core_clk_in(clk), .sys_rst_in(rst), .mp_page_in(page), .mp_addr_in(addr),
		.mp_wr_in(wr), .mp_rd_in(rd), .mp_wdata_in(wdata), .mp_rdata_out(rdata),
		.mp_rvalid_out(rvalid), .slot_strobe_in(stb), .slot_num_in(slot),
		.frame_num_in(frame), .esf_mode_in(esf), .nibble_select_in(nsel),
		.test_pattern_sel_in(tsel), .serial_data_in(sdata), .serial_control_in(ctl),
		.rx_line_in(rxb), .tx_message_in(MSG), .prbs_gen_in(PRBS), .milliwatt_in(MW),
		.slot_ready_out(rdy), .tx_line_out(txd), .tx_line_valid_out(txv),
		.tx_line_ready_in(txr), .serial_data_out(sdo), .serial_data_valid_out(sdv),
		.rx_loop_out(lpo), .rx_loop_valid_out(lpv), .prbs_det_out(deto),
		.prbs_det_valid_out(detv));
	t1_backplane_model u_bp (
		.core_clk_in(clk), .sys_rst_in(rst), .nibble_select_in(nsel), .abcd_in(abcd),
		.serial_control_out(ctl), .stall_in(stall), .line_valid_in(txv),
		.line_data_in(txd), .line_ready_out(txr), .got_out(got), .got_cnt_out(cnt));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic results;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic wreg(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
		page = p;
		addr = a;
		wdata = d;
		wr = 1'b1;
		step;
		wr = 1'b0;
		step; // let an edge pass so back-to-back writes never re-raise the strobe at once
	endtask : wreg
	task automatic rreg(input logic [3:0] p, input logic [4:0] a, input logic [7:0] e);
		page = p;
		addr = a;
		rd = 1'b1;
		step;
		rd = 1'b0;
		chk("read valid", 8'h01, rvalid);
		chk("read data", e, rdata);
		step; // let an edge pass before the next read strobe
	endtask : rreg
	// one slot: receive side checked next cycle, line byte waited for
	task automatic sl(input logic [4:0] n, f, input logic [7:0] d, r, etx, erx,
		input logic lv, dv);
		logic [7:0] c0;
		c0 = cnt;
		slot = n;
		frame = f;
		sdata = d;
		rxb = r;
		stb = 1'b1;
		step;
		stb = 1'b0;
		sdata = ~d;
		rxb = ~r;
		chk("rx byte", erx, sdo);
		chk("loop valid", lv, lpv);
		if (lv) chk("loop byte", etx, lpo);
		chk("det valid", dv, detv);
		if (dv) chk("det byte", r, deto);
		for (int i = 0; i < 40 && cnt === c0; i++) step;
		if (cnt === c0) begin
			$display("FAIL line byte expected arrival seen none");
			miscompares++;
			results;
		end
		chk("tx byte", etx, got);
	endtask : sl
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_regs;
		rreg(PAGE_SLOT_CTRL_LO, 5'h15, SLOT_CTRL_RESET);
		rreg(PAGE_TX_SIG_LO, 5'h10, {4'h0, TX_SIG_RESET});
		wreg(PAGE_TX_SIG_LO, 5'h10, 8'hfa);
		rreg(PAGE_TX_SIG_LO, 5'h10, 8'h0a);
		wreg(PAGE_TX_SIG_HI, 5'h17, 8'h38);
		rreg(PAGE_TX_SIG_HI, 5'h17, 8'h08);
		wreg(PAGE_TX_SIG_HI, 5'h18, 8'h0f);
		rreg(PAGE_TX_SIG_HI, 5'h18, 8'h00);
		wreg(PAGE_SLOT_CTRL_LO, 5'h1f, 8'ha5);
		rreg(PAGE_SLOT_CTRL_LO, 5'h1f, 8'ha5);
		wreg(PAGE_SLOT_CTRL_HI, 5'h18, 8'h77);
		rreg(PAGE_SLOT_CTRL_HI, 5'h18, 8'h00);
		rreg(PAGE_SLOT_CTRL_LO, 5'h0f, 8'h00);
	endtask : sc_regs
	task automatic sc_sig_ram;
		esf = 1'b1;
		wreg(PAGE_SLOT_CTRL_LO, 5'h10, 8'h02);
		wreg(PAGE_SLOT_CTRL_HI, 5'h17, 8'h02);
		sl(5'd0, FRAME_SIG_A, 8'h54, 8'h21, 8'h55, 8'h21, 0, 0);
		sl(5'd0, FRAME_SIG_B, 8'h55, 8'h21, 8'h54, 8'h21, 0, 0);
		sl(5'd0, FRAME_SIG_C, 8'h54, 8'h21, 8'h55, 8'h21, 0, 0);
		sl(5'd0, FRAME_SIG_D, 8'h55, 8'h21, 8'h54, 8'h21, 0, 0);
		sl(5'd0, 5'd3, 8'h55, 8'h21, 8'h55, 8'h21, 0, 0);
		sl(5'd23, FRAME_SIG_A, 8'h54, 8'h21, 8'h55, 8'h21, 0, 0);
		esf = 1'b0;
		sl(5'd0, FRAME_SIG_C, 8'h54, 8'h21, 8'h54, 8'h21, 0, 0);
		sl(5'd0, FRAME_SIG_A, 8'h54, 8'h21, 8'h55, 8'h21, 0, 0);
	endtask : sc_sig_ram
	task automatic sc_sig_serial;
		esf = 1'b1;
		abcd = 4'h5;
		nsel = 1'b1;
		sl(5'd1, FRAME_SIG_A, 8'h55, 8'h21, 8'h54, 8'h21, 0, 0);
		sl(5'd1, FRAME_SIG_B, 8'h54, 8'h21, 8'h55, 8'h21, 0, 0);
		nsel = 1'b0;
		sl(5'd1, FRAME_SIG_D, 8'h54, 8'h21, 8'h55, 8'h21, 0, 0);
		sl(5'd1, FRAME_SIG_C, 8'h55, 8'h21, 8'h54, 8'h21, 0, 0);
	endtask : sc_sig_serial
	task automatic sc_slot_ctrl;
		wreg(PAGE_SLOT_CTRL_LO, 5'h12, 8'h03);
		wreg(PAGE_TX_SIG_LO, 5'h12, 8'h0f);
		sl(5'd2, FRAME_SIG_A, 8'h54, 8'h21, 8'h54, 8'h21, 0, 0);
		wreg(PAGE_SLOT_CTRL_LO, 5'h13, 8'h81);
		sl(5'd3, 5'd0, 8'h11, 8'h0f, MSG, 8'h0f, 0, 0);
		wreg(PAGE_SLOT_CTRL_LO, 5'h14, 8'h41);
		sl(5'd4, 5'd0, 8'h0f, 8'h33, 8'hf0, 8'hcc, 0, 0);
		wreg(PAGE_SLOT_CTRL_LO, 5'h15, 8'h21);
		sl(5'd5, 5'd0, 8'h11, 8'h5a, 8'h5a, 8'h5a, 0, 0);
		wreg(PAGE_SLOT_CTRL_LO, 5'h16, 8'h11);
		sl(5'd6, 5'd0, 8'h66, 8'h99, 8'h66, 8'h66, 1, 0);
	endtask : sc_slot_ctrl
	task automatic sc_test;
		wreg(PAGE_SLOT_CTRL_LO, 5'h17, 8'h09);
		wreg(PAGE_SLOT_CTRL_LO, 5'h18, 8'h05);
		tsel = 1'b1;
		sl(5'd7, 5'd0, 8'h11, 8'h22, MW, 8'h22, 0, 0);
		sl(5'd8, 5'd0, 8'h11, 8'h22, 8'h11, MW, 0, 0);
		tsel = 1'b0;
		sl(5'd7, 5'd0, 8'h11, 8'h22, PRBS, 8'h22, 0, 0);
		sl(5'd8, 5'd0, 8'h11, 8'h22, 8'h11, 8'h22, 0, 1);
	endtask : sc_test
	// fill the buffer against a stalled line, refuse one, then drain
	task automatic sc_fifo;
		logic [7:0] c0;
		int         n;
		c0 = cnt;
		n = 0;
		stall = 1'b1;
		slot = 5'd9;
		frame = 5'd0;
		for (int i = 0; i < 20 && rdy === 1'b1; i++) begin
			sdata = 8'(i);
			stb = 1'b1;
			n++;
			step;
		end
		stb = 1'b0;
		chk("fill count", 8'(TX_FIFO_DEPTH + 1), 8'(n));
		chk("ready while full", 8'h00, rdy);
		step;
		stb = 1'b1;
		step;
		stb = 1'b0;
		chk("dropped slot", 8'h00, sdv);
		stall = 1'b0;
		for (int i = 0; i < 60 && cnt !== c0 + 8'(n); i++) step;
		chk("drained count", c0 + 8'(n), cnt);
		chk("last byte", 8'(n - 1), got);
	endtask : sc_fifo
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (2) step;
		chk("ready after reset", 8'h01, rdy);
		chk("line idle after reset", 8'h00, txv);
		chk("rx idle after reset", 8'h00, sdv);
		sc_regs;
		sc_sig_ram;
		sc_sig_serial;
		sc_slot_ctrl;
		sc_test;
		sc_fifo;
		results;
	end
endmodule : tb_t1_tx_signaling_timeslot_ctrl
